// [src/rif_consts.vh]
// rif_consts.vh: register map, field positions and reset values of the rgb insertion block
// assumes a 32-bit axi4-lite slave with one aligned word per register
`ifndef RIF_CONSTS_VH
`define RIF_CONSTS_VH

// register byte offsets
`define RIF_CTRL_OFS        8'h00
`define RIF_MON_OFS         8'h04
`define RIF_VID_OFS         8'h08
`define RIF_EXTA_OFS        8'h0C
`define RIF_EXTB_OFS        8'h10
`define RIF_IRQ_STAT_OFS    8'h14
`define RIF_IRQ_MASK_OFS    8'h18
`define RIF_SRC_OFS         8'h1C

// control register fields
`define RIF_CTRL_POL_BIT    0
`define RIF_CTRL_PRIO_BIT   1
`define RIF_CTRL_MONSEL_BIT 2
`define RIF_CTRL_OVER_BIT   3
`define RIF_CTRL_RST        4'h0

// monitor register fields
`define RIF_MON_STATIC_BIT  0
`define RIF_MON_DYN_BIT     1

// external gain register layout: brightness [7:0], contrast [15:8]
`define RIF_GAIN_RST        16'h8000
`define RIF_VID_RST         16'h0000

// interrupt status bits
`define RIF_IRQ_FALL_BIT    0
`define RIF_IRQ_SRC_BIT     1

// source selection codes
`define RIF_SRC_VIDEO       2'h0
`define RIF_SRC_A           2'h1
`define RIF_SRC_B           2'h2

// axi responses
`define RIF_RESP_OKAY       2'h0
`define RIF_RESP_SLVERR     2'h2

`endif

// [src/rif_rgb_insert.v]
// rif_rgb_insert.v: rgb source select, fast blank monitor, half contrast, axi4-lite registers
// assumes all inputs synchronous to core_clk_i; colour words are digitised samples of the sources
//
// Functional notes
// - polarity 0: high blank picks its source
// - polarity 1: low blank picks its source
// - two clamped sources switched by fast blank
// - external source goes over or under video
// - separate brightness and contrast per source
// - two-bit monitor status readable by host
// - static bit follows monitored line directly
// - dynamic bit set by falling edge
// - host selects which blank line monitored
// - half contrast reduces video contrast
// - inserted sources keep full contrast
// - half contrast halves video output level
`timescale 1ns/1ps
`include "rif_consts.vh"

module rif_rgb_insert #(
	parameter CW = 10 // colour sample width
) (
	// clock and reset
	input  wire          core_clk_i,
	input  wire          arst_n_i,
	// internal video
	input  wire [CW-1:0] red_vid_i,
	input  wire [CW-1:0] green_vid_i,
	input  wire [CW-1:0] blue_vid_i,
	input  wire          vid_key_i,
	// external source a
	input  wire [CW-1:0] red_in_a_i,
	input  wire [CW-1:0] green_in_a_i,
	input  wire [CW-1:0] blue_in_a_i,
	// external source b
	input  wire [CW-1:0] red_in_b_i,
	input  wire [CW-1:0] green_in_b_i,
	input  wire [CW-1:0] blue_in_b_i,
	// insertion controls
	input  wire          fast_blank_in_a_i,
	input  wire          fast_blank_in_b_i,
	input  wire          half_contrast_in_i,
	input  wire          clamp_key_i,
	// main rgb out
	output reg  [CW-1:0] red_o,
	output reg  [CW-1:0] green_o,
	output reg  [CW-1:0] blue_o,
	output reg  [1:0]    src_o,
	// interrupt
	output wire          irq_o,
	// axi4-lite write address
	input  wire [7:0]    s_axi_awaddr,
	input  wire          s_axi_awvalid,
	output wire          s_axi_awready,
	// axi4-lite write data
	input  wire [31:0]   s_axi_wdata,
	input  wire [3:0]    s_axi_wstrb,
	input  wire          s_axi_wvalid,
	output wire          s_axi_wready,
	// axi4-lite write response
	output reg  [1:0]    s_axi_bresp,
	output reg           s_axi_bvalid,
	input  wire          s_axi_bready,
	// axi4-lite read address
	input  wire [7:0]    s_axi_araddr,
	input  wire          s_axi_arvalid,
	output wire          s_axi_arready,
	// axi4-lite read data
	output reg  [31:0]   s_axi_rdata,
	output reg  [1:0]    s_axi_rresp,
	output reg           s_axi_rvalid,
	input  wire          s_axi_rready
);

	////////////////////////////////////////////////////////////////////////////////
	// functions

	// scale sample by 8-bit gain (0x80 = unity), add offset, saturate
	function [CW-1:0] scale;
		input [CW-1:0] s;
		input [7:0]    g;
		input [7:0]    o;
		reg   [CW+8:0] p;
		begin
			p = ({9'h000, s} * {{CW{1'b0}}, 1'b0, g}) >> 7;
			p = p + {{(CW+1){1'b0}}, o};
			if (p > {9'h000, {CW{1'b1}}}) begin
				scale = {CW{1'b1}}; // clip at full scale
			end else begin
				scale = p[CW-1:0];
			end
		end
	endfunction

	// source decode from fast blank levels and settings
	function [1:0] pick;
		input a, b, pol, prio;
		reg   ea, eb;
		begin
			ea = a ^ pol; // active level after polarity
			eb = b ^ pol;
			if (ea && eb) begin
				pick = prio ? `RIF_SRC_B : `RIF_SRC_A;
			end else if (ea) begin
				pick = `RIF_SRC_A;
			end else if (eb) begin
				pick = `RIF_SRC_B;
			end else begin
				pick = `RIF_SRC_VIDEO;
			end
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// registers

	reg  [3:0]    ctrl;        // polarity, priority, monitor select, overlay
	reg  [15:0]   vid_gain;    // video brightness / contrast
	reg  [15:0]   gain_a;      // source a brightness / contrast
	reg  [15:0]   gain_b;      // source b brightness / contrast
	reg  [1:0]    irq_stat;    // sticky events
	reg  [1:0]    irq_mask;    // enables
	reg           dyn_flag;    // falling edge latch
	reg  [1:0]    fb_a_s;      // blank a synchroniser
	reg  [1:0]    fb_b_s;      // blank b synchroniser
	reg  [1:0]    hc_s;        // half contrast synchroniser
	reg           mon_d;       // delayed monitored level
	reg  [CW-1:0] clamp_a [0:2]; // per-colour clamp levels source a
	reg  [CW-1:0] clamp_b [0:2]; // per-colour clamp levels source b
	reg  [1:0]    src_prev;    // last selection, for change event

	wire          pol   = ctrl[`RIF_CTRL_POL_BIT];
	wire          prio  = ctrl[`RIF_CTRL_PRIO_BIT];
	wire          msel  = ctrl[`RIF_CTRL_MONSEL_BIT];
	wire          over  = ctrl[`RIF_CTRL_OVER_BIT];
	wire          fb_a  = fb_a_s[1];
	wire          fb_b  = fb_b_s[1];
	wire          hc    = hc_s[1];
	wire          mon   = msel ? fb_b : fb_a;
	wire          fall  = mon_d & ~mon;

	////////////////////////////////////////////////////////////////////////////////
	// axi4-lite slave: one write and one read at a time

	reg           aw_got;      // address held
	reg           w_got;       // data held
	reg  [7:0]    aw_q;
	reg  [31:0]   w_q;
	reg  [3:0]    ws_q;
	wire          do_wr = aw_got & w_got & ~s_axi_bvalid;
	wire          rd_go = s_axi_arvalid & s_axi_arready;
	wire          rd_mon = rd_go & (s_axi_araddr == `RIF_MON_OFS);
	wire          rd_stat = rd_go & (s_axi_araddr == `RIF_IRQ_STAT_OFS);

	assign s_axi_awready = ~aw_got & ~s_axi_bvalid;
	assign s_axi_wready  = ~w_got & ~s_axi_bvalid;
	assign s_axi_arready = ~s_axi_rvalid;

	// byte-lane merge of a 16-bit register
	function [15:0] merge;
		input [15:0] old;
		input [31:0] d;
		input [3:0]  st;
		begin
			merge = {st[1] ? d[15:8] : old[15:8], st[0] ? d[7:0] : old[7:0]};
		end
	endfunction

	// write channel capture and register writes
	always @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			aw_got       <= 1'b0;
			w_got        <= 1'b0;
			aw_q         <= 8'h00;
			w_q          <= 32'h0000_0000;
			ws_q         <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `RIF_RESP_OKAY;
			ctrl         <= `RIF_CTRL_RST;
			vid_gain     <= `RIF_VID_RST;
			gain_a       <= `RIF_GAIN_RST;
			gain_b       <= `RIF_GAIN_RST;
			irq_mask     <= 2'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_got <= 1'b1;
				aw_q   <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_got <= 1'b1;
				w_q   <= s_axi_wdata;
				ws_q  <= s_axi_wstrb;
			end
			if (do_wr) begin
				aw_got       <= 1'b0;
				w_got        <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= `RIF_RESP_OKAY;
				case (aw_q)
					`RIF_CTRL_OFS: begin
						if (ws_q[0]) ctrl <= w_q[3:0];
					end
					`RIF_VID_OFS:      vid_gain <= merge(vid_gain, w_q, ws_q);
					`RIF_EXTA_OFS:     gain_a   <= merge(gain_a, w_q, ws_q);
					`RIF_EXTB_OFS:     gain_b   <= merge(gain_b, w_q, ws_q);
					`RIF_IRQ_MASK_OFS: begin
						if (ws_q[0]) irq_mask <= w_q[1:0];
					end
					`RIF_MON_OFS, `RIF_IRQ_STAT_OFS, `RIF_SRC_OFS: ; // read only, ignored
					default:           s_axi_bresp <= `RIF_RESP_SLVERR; // unmapped
				endcase
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// read channel: data registered one cycle after address taken
	always @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= `RIF_RESP_OKAY;
		end else if (rd_go) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= `RIF_RESP_OKAY;
			case (s_axi_araddr)
				`RIF_CTRL_OFS:     s_axi_rdata <= {28'h0000000, ctrl};
				`RIF_MON_OFS:      s_axi_rdata <= {30'h00000000, dyn_flag, mon};
				`RIF_VID_OFS:      s_axi_rdata <= {16'h0000, vid_gain};
				`RIF_EXTA_OFS:     s_axi_rdata <= {16'h0000, gain_a};
				`RIF_EXTB_OFS:     s_axi_rdata <= {16'h0000, gain_b};
				`RIF_IRQ_STAT_OFS: s_axi_rdata <= {30'h00000000, irq_stat};
				`RIF_IRQ_MASK_OFS: s_axi_rdata <= {30'h00000000, irq_mask};
				`RIF_SRC_OFS:      s_axi_rdata <= {30'h00000000, src_o};
				default: begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= `RIF_RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// input sync, monitor and events

	// two-stage sync; monitor reads only the second stage
	always @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			fb_a_s   <= 2'h0;
			fb_b_s   <= 2'h0;
			hc_s     <= 2'h0;
			mon_d    <= 1'b0;
			dyn_flag <= 1'b0;
			irq_stat <= 2'h0;
			src_prev <= `RIF_SRC_VIDEO;
		end else begin
			fb_a_s   <= {fb_a_s[0], fast_blank_in_a_i};
			fb_b_s   <= {fb_b_s[0], fast_blank_in_b_i};
			hc_s     <= {hc_s[0], half_contrast_in_i};
			mon_d    <= mon;
			src_prev <= src_o;
			// edge wins over read clear
			if (fall) begin
				dyn_flag <= 1'b1;
			end else if (rd_mon) begin
				dyn_flag <= 1'b0;
			end
			irq_stat[`RIF_IRQ_FALL_BIT] <= fall | (irq_stat[`RIF_IRQ_FALL_BIT] & ~rd_stat);
			irq_stat[`RIF_IRQ_SRC_BIT]  <= (src_prev != src_o) | (irq_stat[`RIF_IRQ_SRC_BIT] & ~rd_stat);
		end
	end

	assign irq_o = |(irq_stat & irq_mask);

	////////////////////////////////////////////////////////////////////////////////
	// key clamp and video path

	// sample each source's black level during the clamp key
	always @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			clamp_a[0] <= {CW{1'b0}};
			clamp_a[1] <= {CW{1'b0}};
			clamp_a[2] <= {CW{1'b0}};
			clamp_b[0] <= {CW{1'b0}};
			clamp_b[1] <= {CW{1'b0}};
			clamp_b[2] <= {CW{1'b0}};
		end else if (clamp_key_i) begin
			clamp_a[0] <= red_in_a_i;
			clamp_a[1] <= green_in_a_i;
			clamp_a[2] <= blue_in_a_i;
			clamp_b[0] <= red_in_b_i;
			clamp_b[1] <= green_in_b_i;
			clamp_b[2] <= blue_in_b_i;
		end
	end

	// remove clamp level without underflow
	function [CW-1:0] unclamp;
		input [CW-1:0] s;
		input [CW-1:0] c;
		begin
			unclamp = (s > c) ? s - c : {CW{1'b0}};
		end
	endfunction

	reg  [1:0]    next_src;
	reg  [CW-1:0] next_r;
	reg  [CW-1:0] next_g;
	reg  [CW-1:0] next_b;
	reg  [1:0]    sel;

	// source choice and level shaping
	always @* begin
		sel = pick(fb_a, fb_b, pol, prio);
		// underlay: video key wins over the external source
		if (!over && vid_key_i) begin
			next_src = `RIF_SRC_VIDEO;
		end else begin
			next_src = sel;
		end
		case (next_src)
			`RIF_SRC_A: begin // full contrast regardless of half contrast
				next_r = scale(unclamp(red_in_a_i, clamp_a[0]), gain_a[15:8], gain_a[7:0]);
				next_g = scale(unclamp(green_in_a_i, clamp_a[1]), gain_a[15:8], gain_a[7:0]);
				next_b = scale(unclamp(blue_in_a_i, clamp_a[2]), gain_a[15:8], gain_a[7:0]);
			end
			`RIF_SRC_B: begin
				next_r = scale(unclamp(red_in_b_i, clamp_b[0]), gain_b[15:8], gain_b[7:0]);
				next_g = scale(unclamp(green_in_b_i, clamp_b[1]), gain_b[15:8], gain_b[7:0]);
				next_b = scale(unclamp(blue_in_b_i, clamp_b[2]), gain_b[15:8], gain_b[7:0]);
			end
			default: begin // video, halved inside the half contrast box
				next_r = scale(red_vid_i, vid_gain[15:8] ^ 8'h80, vid_gain[7:0]) >> hc;
				next_g = scale(green_vid_i, vid_gain[15:8] ^ 8'h80, vid_gain[7:0]) >> hc;
				next_b = scale(blue_vid_i, vid_gain[15:8] ^ 8'h80, vid_gain[7:0]) >> hc;
			end
		endcase
	end

	// registered outputs; no timing correction of external inputs
	always @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			red_o   <= {CW{1'b0}};
			green_o <= {CW{1'b0}};
			blue_o  <= {CW{1'b0}};
			src_o   <= `RIF_SRC_VIDEO;
		end else begin
			red_o   <= next_r;
			green_o <= next_g;
			blue_o  <= next_b;
			src_o   <= next_src;
		end
	end

endmodule

// [verif/rif_rgb_insert_bench.sv]
// bench: source selection, monitor, half contrast and register bus
// assumes the design answers the bus within the watchdog span
`timescale 1ns/1ps
`include "rif_consts.vh"
module rif_rgb_insert_bench;
	logic clk = 0, rst_n = 0, hc = 0, pol = 0, aa = 0, ab = 0;
	logic [9:0] rv = 0, gv = 0, ra = 0, ga = 0, rb = 0, gb = 0;
	logic [7:0] awa = 0, ara = 0;
	logic [31:0] wd = 0;
	logic awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
	wire fa, fb, irq, awr, wrdy, bvld, arr, rvld;
	wire [9:0] ro;
	wire [1:0] src, brsp, rrsp;
	wire [31:0] rdat;
	int failures = 0, tests_run = 0;
	logic [34:0] q[$]; // read notes: don't-care, resp, data
	logic [34:0] n;
	////////////////////////////////////////////////////////////////
	rif_rgb_insert #(.CW(10)) i_rif_rgb_insert(.core_clk_i(clk), .arst_n_i(rst_n),
		.red_vid_i(rv), .green_vid_i(gv), .blue_vid_i(rv), .vid_key_i(1'b0),
		.red_in_a_i(ra), .green_in_a_i(ga), .blue_in_a_i(ra), .red_in_b_i(rb),
		.green_in_b_i(gb), .blue_in_b_i(rb), .fast_blank_in_a_i(fa),
		.fast_blank_in_b_i(fb), .half_contrast_in_i(hc), .clamp_key_i(1'b0),
		.red_o(ro), .green_o(), .blue_o(), .src_o(src), .irq_o(irq),
		.s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
		.s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wrdy),
		.s_axi_bresp(brsp), .s_axi_bvalid(bvld), .s_axi_bready(bre),
		.s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
		.s_axi_rdata(rdat), .s_axi_rresp(rrsp), .s_axi_rvalid(rvld), .s_axi_rready(rre));
	rif_src_model i_rif_src_model(.clk(clk), .pol(pol), .act_a(aa), .act_b(ab), .fb_a(fa), .fb_b(fb));
	initial forever #20 clk = ~clk;
	////////////////////////////////////////////////////////////////
	task chk(string s, logic [33:0] v, logic [33:0] e);
		tests_run++;
		if (v !== e) begin
			failures++;
			$display("wrong value %s exp %h seen %h", s, e, v);
		end
	endtask
	task conclude;
		$display("checks %0d failures %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// write: both items offered, each dropped once taken, then response
	task wr(logic [7:0] a, logic [31:0] d, logic [1:0] er);
		logic x, y, z;
		logic [1:0] r;
		@(posedge clk);
		awa <= a; wd <= d; awv <= 1; wv <= 1; bre <= 1;
		do begin
			@(negedge clk); x = awr & awv; y = wrdy & wv; z = bvld; r = brsp;
			@(posedge clk); if (x) awv <= 0; if (y) wv <= 0;
		end while (!z);
		bre <= 0;
		chk("bresp", r, er);
	endtask
	// read: note goes in the queue, the watcher compares
	task rd(logic [7:0] a, logic [33:0] e, logic dc);
		logic x, y;
		q.push_back({dc, e});
		@(posedge clk);
		ara <= a; arv <= 1; rre <= 1;
		do begin
			@(negedge clk); x = arr & arv; y = rvld;
			@(posedge clk); if (x) arv <= 0;
		end while (!y);
		rre <= 0;
	endtask
	always @(negedge clk) if (rvld === 1'b1 && rre === 1'b1) begin
		n = q.pop_front();
		if (!n[34]) chk("rdata", {rrsp, rdat}, n[33:0]);
	end
	task settle;
		repeat (5) @(posedge clk);
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		failures++;
		conclude;
	end
	////////////////////////////////////////////////////////////////
	initial begin
		logic [1:0] e;
		void'($urandom(32'hBCB87776));
		repeat (5) @(posedge clk);
		rst_n <= 1;
		rd(`RIF_CTRL_OFS, 34'h0, 0);
		rd(`RIF_IRQ_MASK_OFS, 34'h0, 0);
		rd(`RIF_SRC_OFS, 34'h0, 0);
		wr(`RIF_EXTA_OFS, 32'h1234, `RIF_RESP_OKAY);
		rd(`RIF_EXTA_OFS, 34'h1234, 0);
		rd(`RIF_EXTB_OFS, 34'h8000, 0);
		wr(`RIF_EXTA_OFS, 32'h8000, `RIF_RESP_OKAY);
		// every polarity, priority and blank combination
		for (int i = 0; i < 16; i++) begin
			wr(`RIF_CTRL_OFS, {28'h0, 2'b10, i[2], i[3]}, `RIF_RESP_OKAY);
			pol <= i[3]; aa <= i[1]; ab <= i[0]; hc <= 1'($urandom);
			rv <= 10'($urandom); ra <= 10'($urandom); rb <= 10'($urandom);
			gv <= 10'($urandom); ga <= 10'($urandom); gb <= 10'($urandom);
			e = (i[1] & i[0]) ? (i[2] ? `RIF_SRC_B : `RIF_SRC_A) : {i[0], i[1]};
			settle;
			rd(`RIF_SRC_OFS, {32'h0, e}, 0);
			@(negedge clk);
			chk("red", ro, e == 0 ? (hc ? rv >> 1 : rv) : (e == 1 ? ra : rb));
		end
		// monitor on line a, falling edge raises the interrupt
		wr(`RIF_CTRL_OFS, 32'h8, `RIF_RESP_OKAY);
		pol <= 0; aa <= 1; ab <= 0;
		settle;
		rd(`RIF_MON_OFS, 34'h0, 1);
		rd(`RIF_IRQ_STAT_OFS, 34'h0, 1);
		wr(`RIF_IRQ_MASK_OFS, 32'h1, `RIF_RESP_OKAY);
		rd(`RIF_MON_OFS, 34'h1, 0);
		@(negedge clk); chk("irq", irq, 0);
		aa <= 0;
		settle;
		@(negedge clk); chk("irq", irq, 1);
		rd(`RIF_MON_OFS, 34'h2, 0);
		rd(`RIF_MON_OFS, 34'h0, 0);
		rd(`RIF_IRQ_STAT_OFS, 34'h3, 0);
		@(negedge clk); chk("irq", irq, 0);
		// monitor on line b, interrupt masked
		wr(`RIF_CTRL_OFS, 32'hC, `RIF_RESP_OKAY);
		wr(`RIF_IRQ_MASK_OFS, 32'h0, `RIF_RESP_OKAY);
		ab <= 1;
		settle;
		rd(`RIF_MON_OFS, 34'h0, 1);
		rd(`RIF_MON_OFS, 34'h1, 0);
		ab <= 0;
		settle;
		@(negedge clk); chk("irq", irq, 0);
		rd(`RIF_MON_OFS, 34'h2, 0);
		rd(`RIF_IRQ_STAT_OFS, 34'h3, 0);
		// unmapped place
		rd(8'h20, {`RIF_RESP_SLVERR, 32'h0}, 0);
		wr(8'h20, 32'h5, `RIF_RESP_SLVERR);
		conclude;
	end
endmodule

// [verif/rif_rgb_insert_properties.sv]
// checker: port relations of the rgb insertion block
// assumes default gains, clamp idle and video key held low
`timescale 1ns/1ps
module rif_rgb_insert_props #(
	parameter CW = 10 // colour sample width
) (
	// clock, reset, pins
	input wire logic          core_clk_i, arst_n_i,
	input wire logic [CW-1:0] red_vid_i, red_in_a_i, green_in_b_i,
	input wire logic          fast_blank_in_a_i, fast_blank_in_b_i, half_contrast_in_i,
	input wire logic [CW-1:0] red_o, green_o,
	input wire logic [1:0]    src_o,
	input wire logic          irq_o,
	// bus handshakes
	input wire logic          s_axi_bvalid, s_axi_bready, s_axi_rvalid, s_axi_rready,
	input wire logic          s_axi_arvalid, s_axi_arready,
	input wire logic [1:0]    s_axi_bresp,
	input wire logic [31:0]   s_axi_rdata
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!arst_n_i);
	////////////////////////////////////////////////////////////////
	// pin history; reset to mixed values so no relation fires early
	logic [3:0] sa, sb; // blank lines
	logic [4:0] sh;     // half contrast
	always @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			sa <= 4'h5;
			sb <= 4'h5;
			sh <= 5'h0A;
		end else begin
			sa <= {sa[2:0], fast_blank_in_a_i};
			sb <= {sb[2:0], fast_blank_in_b_i};
			sh <= {sh[3:0], half_contrast_in_i};
		end
	end
	////////////////////////////////////////////////////////////////
	a_src_legal: assert property (src_o != 2'h3) else $error("bad source code");
	a_excl_blank: assert property ((sa == ~sb) && (sa == 4'h0 || sa == 4'hF) |-> src_o != 2'h0)
		else $error("lone blank not selected");
	a_pass_a: assert property (src_o == 2'h1 |-> red_o == $past(red_in_a_i)) else $error("source a altered");
	a_pass_b: assert property (src_o == 2'h2 |-> green_o == $past(green_in_b_i)) else $error("source b altered");
	a_half_video: assert property (src_o == 2'h0 && sh == 5'h1F |-> red_o == ($past(red_vid_i) >> 1))
		else $error("video not halved");
	a_full_video: assert property (src_o == 2'h0 && sh == 5'h00 |-> red_o == $past(red_vid_i))
		else $error("video not full");
	a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer dropped");
	a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer dropped");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("late read");
	c_src_a: cover property (src_o == 2'h1);
	c_src_b: cover property (src_o == 2'h2);
	c_irq: cover property ($rose(irq_o));
endmodule
bind rif_rgb_insert rif_rgb_insert_props #(.CW(CW)) i_rif_rgb_insert_props (.*);

// [verif/rif_src_model.sv]
// model: external source pair driving the two fast blank lines
// assumes one clock; levels change only after a rising edge
`timescale 1ns/1ps
module rif_src_model (
	// control from bench
	input  wire logic clk,
	input  wire logic pol,   // shared active level
	input  wire logic act_a, // source a wants the screen
	input  wire logic act_b, // source b wants the screen
	// blank lines
	output logic      fb_a = 1'b0,
	output logic      fb_b = 1'b0
);
	// both lines share one polarity, moved on the clock as at flyback
	always @(posedge clk) begin
		fb_a <= act_a ^ pol;
		fb_b <= act_b ^ pol;
	end
endmodule
